// file: src/sequencer_cfg.svh
`ifndef SEQUENCER_CFG_SVH
`define SEQUENCER_CFG_SVH

// clock and time figures
`define CLK_HZ 50000000
`define SOAK_TICK_MS 1000
`define BLINK_MS 500

// register byte offsets
`define REG_CTRL 8'h00
`define REG_BANK 8'h04
`define REG_STAT 8'h08
`define REG_TABLE_BASE 8'h40
`define REG_TABLE_LAST 8'hbf

// table word select within one bank slot
`define TBL_SP 2'h0
`define TBL_SOAK 2'h1
`define TBL_WAIT 2'h2
`define TBL_RAMP 2'h3
`define TBL_SLOT_SHIFT 4

// control register fields
`define CTRL_PAT_LO 0
`define CTRL_PAT_HI 1
`define CTRL_START 2
`define CTRL_MAP_EVT 3
`define CTRL_REMOTE 4
`define CTRL_RUN 5
`define CTRL_LIM_LO 8
`define CTRL_LIM_HI 10

// status register fields
`define STAT_STARTED 0
`define STAT_RUN 1
`define STAT_END 2
`define STAT_SHOW_END 3
`define STAT_RAMP 4
`define STAT_BANK_LO 8
`define STAT_BANK_HI 10
`define STAT_EL_LO 16
`define STAT_EL_HI 31

`endif

// file: src/sequencer_pkg.sv
package sequencer_pkg;

    typedef enum logic [1:0] {PAT_OFF, PAT_STOP, PAT_CONTINUE_PATTERN, PAT_LOOP} pattern_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_END} seq_t;

    typedef struct packed {
        pattern_t pat;
        logic started;
        logic map_evt;
        logic remote;
        logic run;
        logic [2:0] limit;
        logic [2:0] bank;
        seq_t seq;
        logic [15:0] elapsed;
        logic [25:0] tick;
        logic [25:0] blink;
        logic alt;
        logic aux1_end;
        logic alarm_one_function_moved;
        logic ramp_on;
        logic at_prev;
        logic [15:0] pv_cap;
        logic [15:0] rsp_cap;
        logic [7:0][15:0] sp;
        logic [7:0][15:0] soak;
        logic [7:0][15:0] wait_band;
        logic [7:0][15:0] ramp;
        logic ack;
        logic [31:0] rdata;
    } state_t;

endpackage

// file: src/simple_program_sequencer.sv
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
`include "sequencer_cfg.svh"
module simple_program_sequencer
    import sequencer_pkg::*;
#(
    parameter int TICK_CYCLES = `CLK_HZ / 1000 * `SOAK_TICK_MS,
    parameter int BLINK_CYCLES = `CLK_HZ / 1000 * `BLINK_MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [15:0] pv_i,
    input wire logic [15:0] rsp_i,
    input wire logic [15:0] range_upper_i,
    input wire logic input_err_i,
    input wire logic rsp_err_i,
    input wire logic at_active_i,
    input wire logic event_start_i,
    input wire logic event_bank_stb_i,
    input wire logic [2:0] event_bank_i,
    input wire logic power_restore_i,
    output logic end_o,
    output logic run_o,
    output logic [2:0] bank_o,
    output logic show_end_o,
    output logic ramp_on_o,
    output logic aux1_end_o,
    output logic alarm_one_function_moved_o
);

    state_t st;
    state_t n;
    logic wr;
    logic pat_chg;
    logic tick_hit;
    logic adv;
    logic new_start;
    logic [15:0] pv_eff;
    logic [15:0] sp_eff;
    logic [3:0] hit;
    logic [1:0] tsel;
    logic [2:0] tbank;

    // ****************************************
    // helper functions
    // ****************************************

    // first bank at or after from, up to limit, with nonzero soak
    function automatic logic [3:0] find_bank(input logic [3:0] from,
            input logic [2:0] limit, input logic [7:0][15:0] soak);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (r[3] == 1'b0 && 4'(i) >= from && 3'(i) <= limit
                    && soak[i] != 16'h0000) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // process value inside set point plus or minus band, band 0 is off
    function automatic logic in_band(input logic [15:0] pv,
            input logic [15:0] sp, input logic [15:0] wb);
        logic [15:0] d;
        d = (pv > sp) ? pv - sp : sp - pv;
        return (wb == 16'h0000) || (d <= wb);
    endfunction

    // ****************************************
    // next state
    // ****************************************

    always_comb begin
        n = st;
        wr = cyc_i && stb_i && we_i && !st.ack;
        n.ack = cyc_i && stb_i && !st.ack;
        n.rdata = 32'h0000_0000;
        pat_chg = 1'b0;
        adv = 1'b0;
        hit = 4'h0;
        tsel = adr_i[3:2];
        tbank = 3'((adr_i - `REG_TABLE_BASE) >> `TBL_SLOT_SHIFT);
        tick_hit = (st.tick == 26'(TICK_CYCLES - 1));
        n.tick = tick_hit ? 26'h0 : st.tick + 26'h1;
        n.at_prev = at_active_i;
        // capture values while the remote input is healthy
        if (!rsp_err_i) begin
            n.pv_cap = pv_i;
            n.rsp_cap = rsp_i;
        end
        // effective values for the wait band test
        sp_eff = st.remote ? (rsp_err_i ? st.rsp_cap : rsp_i)
                           : st.sp[st.bank];
        if (input_err_i) begin
            pv_eff = range_upper_i;
        end else if (st.remote && rsp_err_i) begin
            pv_eff = st.pv_cap;
        end else begin
            pv_eff = pv_i;
        end
        new_start = st.started;
        // register writes
        if (wr && adr_i == `REG_CTRL) begin
            if (sel_i[0]) begin
                n.pat = pattern_t'(dat_i[`CTRL_PAT_HI:`CTRL_PAT_LO]);
                pat_chg = (n.pat != st.pat);
                if (pat_chg) begin
                    n.bank = 3'h0;
                    n.elapsed = 16'h0000;
                end
                if (st.pat == PAT_OFF && n.pat != PAT_OFF) begin
                    n.aux1_end = 1'b1;
                    n.alarm_one_function_moved = 1'b1;
                end
                if (st.pat != PAT_OFF && n.pat == PAT_OFF) begin
                    n.alarm_one_function_moved = 1'b0;
                    n.aux1_end = 1'b0;
                end
                n.map_evt = dat_i[`CTRL_MAP_EVT] && n.pat != PAT_OFF;
                n.remote = dat_i[`CTRL_REMOTE];
                n.run = dat_i[`CTRL_RUN];
                if (!st.map_evt) begin
                    new_start = dat_i[`CTRL_START];
                end
            end
            if (sel_i[1]) begin
                n.limit = dat_i[`CTRL_LIM_HI:`CTRL_LIM_LO];
            end
        end else if (wr && adr_i == `REG_BANK && sel_i[0]) begin
            n.bank = dat_i[2:0];
            n.elapsed = 16'h0000;
        end else if (wr && adr_i >= `REG_TABLE_BASE
                && adr_i <= `REG_TABLE_LAST && sel_i[1:0] == 2'b11) begin
            // soak edits leave the running count alone
            case (tsel)
                `TBL_SP: n.sp[tbank] = dat_i[15:0];
                `TBL_SOAK: n.soak[tbank] = dat_i[15:0];
                `TBL_WAIT: n.wait_band[tbank] = dat_i[15:0];
                default: n.ramp[tbank] = dat_i[15:0];
            endcase
        end
        // bank change from an event input, a pattern change wins
        if (event_bank_stb_i && st.pat != PAT_OFF && !pat_chg) begin
            n.bank = event_bank_i;
            n.elapsed = 16'h0000;
        end
        // start follows the event when mapped, held across power loss
        if (st.map_evt && n.map_evt && !power_restore_i) begin
            new_start = event_start_i;
        end
        n.started = new_start;
        // start and reset transitions
        if (new_start && !st.started && n.pat != PAT_OFF) begin
            n.seq = SEQ_RUN;
            n.run = 1'b1;
            n.elapsed = 16'h0000;
        end else if (!new_start && st.started) begin
            n.seq = SEQ_IDLE;
            n.bank = 3'h0;
            n.elapsed = 16'h0000;
        end else if (n.pat == PAT_OFF) begin
            n.seq = SEQ_IDLE;
        end else if (st.seq == SEQ_RUN && !pat_chg) begin
            // timing ignores run/stop and manual switching
            if (at_active_i) begin
                n.elapsed = 16'h0000;
            end else if (st.at_prev) begin
                adv = 1'b1;
            end else if (st.soak[st.bank] == 16'h0000) begin
                adv = 1'b1;
            end else if (tick_hit
                    && in_band(pv_eff, sp_eff, st.wait_band[st.bank])) begin
                n.elapsed = st.elapsed + 16'h0001;
                adv = (n.elapsed >= st.soak[st.bank]);
            end
        end
        // bank advance and program end
        if (adv) begin
            hit = find_bank({1'b0, st.bank} + 4'h1, st.limit, st.soak);
            if (!hit[3] && st.pat == PAT_LOOP) begin
                hit = find_bank(4'h0, st.limit, st.soak);
            end
            n.elapsed = 16'h0000;
            if (hit[3]) begin
                n.bank = hit[2:0];
                n.ramp_on = (st.ramp[hit[2:0]] != 16'h0000);
            end else begin
                n.seq = SEQ_END;
                if (st.pat == PAT_STOP) begin
                    n.run = 1'b0;
                end
            end
        end
        // power recovery restarts the soak count only
        if (power_restore_i) begin
            n.elapsed = 16'h0000;
            n.tick = 26'h0;
        end
        // end display alternation
        if (n.seq == SEQ_END) begin
            if (st.blink == 26'(BLINK_CYCLES - 1)) begin
                n.blink = 26'h0;
                n.alt = !st.alt;
            end else begin
                n.blink = st.blink + 26'h1;
            end
        end else begin
            n.blink = 26'h0;
            n.alt = 1'b0;
        end
        // read data
        if (adr_i == `REG_CTRL) begin
            n.rdata[`CTRL_PAT_HI:`CTRL_PAT_LO] = st.pat;
            n.rdata[`CTRL_START] = st.started;
            n.rdata[`CTRL_MAP_EVT] = st.map_evt;
            n.rdata[`CTRL_REMOTE] = st.remote;
            n.rdata[`CTRL_RUN] = st.run;
            n.rdata[`CTRL_LIM_HI:`CTRL_LIM_LO] = st.limit;
        end else if (adr_i == `REG_BANK) begin
            n.rdata[2:0] = st.bank;
        end else if (adr_i == `REG_STAT) begin
            n.rdata[`STAT_STARTED] = st.started;
            n.rdata[`STAT_RUN] = st.run;
            n.rdata[`STAT_END] = (st.seq == SEQ_END);
            n.rdata[`STAT_SHOW_END] = st.alt;
            n.rdata[`STAT_RAMP] = st.ramp_on;
            n.rdata[`STAT_BANK_HI:`STAT_BANK_LO] = st.bank;
            n.rdata[`STAT_EL_HI:`STAT_EL_LO] = st.elapsed;
        end else if (adr_i >= `REG_TABLE_BASE && adr_i <= `REG_TABLE_LAST) begin
            case (tsel)
                `TBL_SP: n.rdata[15:0] = st.sp[tbank];
                `TBL_SOAK: n.rdata[15:0] = st.soak[tbank];
                `TBL_WAIT: n.rdata[15:0] = st.wait_band[tbank];
                default: n.rdata[15:0] = st.ramp[tbank];
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    // outputs straight from the state register
    assign dat_o = st.rdata;
    assign ack_o = st.ack;
    assign end_o = (st.seq == SEQ_END);
    assign run_o = st.run;
    assign bank_o = st.bank;
    assign show_end_o = st.alt;
    assign ramp_on_o = st.ramp_on;
    assign aux1_end_o = st.aux1_end;
    assign alarm_one_function_moved_o = st.alarm_one_function_moved;

    // ****************************************
    // assertions
    // ****************************************

    power_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        power_restore_i |=> st.elapsed == 16'h0000)
        else $error("elapsed soak not cleared after power recovery");

    power_keep_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (power_restore_i && !wr) |=> st.started == $past(st.started))
        else $error("start state lost over power recovery");

    pattern_bank_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pat_chg |=> st.bank == 3'h0)
        else $error("bank not zero after pattern change");

    end_clear_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(st.started) |-> st.seq != SEQ_END && !st.alt)
        else $error("end status survived program reset");

    at_hold_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (at_active_i && st.seq == SEQ_RUN) |=> st.elapsed == 16'h0000
            && st.bank == $past(st.bank) || $past(wr || event_bank_stb_i))
        else $error("soak advanced during auto-tuning");

    aux_assign_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.pat != PAT_OFF && $past(st.pat) == PAT_OFF)
            |-> st.aux1_end && st.alarm_one_function_moved)
        else $error("end output not on auxiliary 1");

    alarm_restore_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.pat == PAT_OFF && $past(st.pat) != PAT_OFF)
            |-> !st.alarm_one_function_moved && !st.aux1_end)
        else $error("alarm 1 not restored");

    stop_end_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ($rose(st.seq == SEQ_END) && st.pat == PAT_STOP) |-> !st.run)
        else $error("stop pattern kept running at end");

    event_ro_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.map_evt && $past(st.map_evt) && !$past(power_restore_i)
            && st.pat == $past(st.pat))
            |-> st.started == $past(event_start_i))
        else $error("mapped start did not follow event");

    blink_rate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (st.seq == SEQ_END && $past(st.seq) == SEQ_END
            && st.alt != $past(st.alt)) |-> $past(st.blink) ==
            26'(BLINK_CYCLES - 1))
        else $error("end display toggled off its period");

endmodule // simple_program_sequencer

// file: testbench/simple_program_sequencer_tb.sv
`timescale 1ns/100ps
`include "sequencer_cfg.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module simple_program_sequencer_tb;
    import sequencer_pkg::*;
    localparam int TICK = 10;
    localparam int BLINK = 4;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [15:0] pv_i, rsp_i, range_upper_i, el;
    logic input_err_i, rsp_err_i, at_active_i, event_start_i;
    logic event_bank_stb_i, power_restore_i;
    logic [2:0] event_bank_i, bank_o;
    logic end_o, run_o, show_end_o, ramp_on_o, aux1_end_o, alarm_one_function_moved_o;
    logic prev, seen1;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    int toggles;

    simple_program_sequencer #(.TICK_CYCLES(TICK), .BLINK_CYCLES(BLINK)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .pv_i(pv_i), .rsp_i(rsp_i),
        .range_upper_i(range_upper_i), .input_err_i(input_err_i),
        .rsp_err_i(rsp_err_i), .at_active_i(at_active_i),
        .event_start_i(event_start_i), .event_bank_stb_i(event_bank_stb_i),
        .event_bank_i(event_bank_i), .power_restore_i(power_restore_i),
        .end_o(end_o), .run_o(run_o), .bank_o(bank_o),
        .show_end_o(show_end_o), .ramp_on_o(ramp_on_o),
        .aux1_end_o(aux1_end_o), .alarm_one_function_moved_o(alarm_one_function_moved_o));

    // ****************************************
    // clock, timeout and bus tasks
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // cut a hung run short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one classic cycle; read data taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic rd_el();
        wb(1'b0, `REG_STAT, 32'h0);
        el = rd[`STAT_EL_HI:`STAT_EL_LO];
    endtask

    task automatic set_bank(input int b, input logic [15:0] sp, soak,
            wbd, rp);
        logic [7:0] base;
        base = `REG_TABLE_BASE + 8'(b * 16);
        wb(1'b1, base, {16'h0, sp});
        wb(1'b1, base + 8'h04, {16'h0, soak});
        wb(1'b1, base + 8'h08, {16'h0, wbd});
        wb(1'b1, base + 8'h0c, {16'h0, rp});
    endtask

    // wait for a bank under a bound, noting whether bank 1 showed up
    task automatic wait_bank(input logic [2:0] b, input int lim);
        int n;
        n = 0;
        while (bank_o !== b && n < lim) begin
            @(negedge clk_i);
            if (bank_o === 3'h1) seen1 = 1'b1;
            n++;
        end
        `CHK("bank reached", b, bank_o)
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
        adr_i = 8'h00; sel_i = 4'hf; dat_i = 32'h0; pv_i = 16'h0064;
        rsp_i = 16'h0064; range_upper_i = 16'h0067; input_err_i = 1'b0;
        rsp_err_i = 1'b0; at_active_i = 1'b0; event_start_i = 1'b1;
        event_bank_stb_i = 1'b0; event_bank_i = 3'h0;
        power_restore_i = 1'b0; seen1 = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK("reset outs", 4'h0, {end_o, run_o, aux1_end_o, alarm_one_function_moved_o})
        set_bank(0, 16'h0064, 16'h0005, 16'h0005, 16'h0000);
        set_bank(2, 16'h00c8, 16'h0002, 16'h0000, 16'h0007);
        wb(1'b1, `REG_CTRL, 32'h1);
        `CHK("aux1 end", 2'h3, {aux1_end_o, alarm_one_function_moved_o})
        `CHK("bank pat", 3'h0, bank_o)
        @(posedge clk_i);
        pv_i <= 16'h00c8;
        wb(1'b1, `REG_CTRL, 32'h225);
        `CHK("run", 1'b1, run_o)
        cyc_n(40);
        rd_el();
        `CHK("out of band", 16'h0, el)
        @(posedge clk_i);
        input_err_i <= 1'b1;
        cyc_n(15);
        rd_el();
        `CHK("sensor err timing", 1'b1, el != 16'h0)
        @(posedge clk_i);
        input_err_i <= 1'b0;
        pv_i <= 16'h0064;
        wb(1'b1, `REG_CTRL, 32'h205);
        `CHK("stopped", 1'b0, run_o)
        rd_el();
        prev = el[0];
        wb(1'b1, 8'h44, 32'h8);
        wb(1'b1, `REG_CTRL, 32'h225);
        wb(1'b0, `REG_STAT, 32'h0);
        `CHK("soak edit keeps", 1'b1, rd[31:16] >= el)
        @(posedge clk_i);
        power_restore_i <= 1'b1;
        @(posedge clk_i);
        power_restore_i <= 1'b0;
        @(negedge clk_i);
        `CHK("restore run", 1'b1, run_o)
        rd_el();
        `CHK("restore elapsed", 16'h0, el)
        wait_bank(3'h2, 200);
        `CHK("ramp carried", 1'b1, ramp_on_o)
        `CHK("skip zero soak", 1'b0, seen1)
        for (int n = 0; n < 100 && end_o !== 1'b1; n++) @(negedge clk_i);
        `CHK("end out", 1'b1, end_o)
        `CHK("end bank held", 3'h2, bank_o)
        `CHK("stop at end", 1'b0, run_o)
        toggles = 0;
        prev = show_end_o;
        for (int n = 0; n < 16; n++) begin
            @(negedge clk_i);
            if (show_end_o !== prev) toggles++;
            prev = show_end_o;
        end
        `CHK("blink count", 16 / BLINK, toggles)
        wb(1'b1, `REG_CTRL, 32'h221);
        `CHK("end clear", 5'h00, {end_o, show_end_o, bank_o})
        wb(1'b1, `REG_CTRL, 32'h225);
        cyc_n(15);
        wb(1'b1, `REG_BANK, 32'h2);
        `CHK("key bank", 3'h2, bank_o)
        @(posedge clk_i);
        pv_i <= 16'h0000;
        event_bank_stb_i <= 1'b1;
        @(posedge clk_i);
        event_bank_stb_i <= 1'b0;
        @(negedge clk_i);
        `CHK("event bank", 3'h0, bank_o)
        rd_el();
        `CHK("bank change clears", 16'h0, el)
        @(posedge clk_i);
        pv_i <= 16'h0064;
        at_active_i <= 1'b1;
        cyc_n(60);
        rd_el();
        `CHK("tuning holds", 19'h0, {bank_o, el})
        @(posedge clk_i);
        at_active_i <= 1'b0;
        cyc_n(5);
        `CHK("tuning done", 3'h2, bank_o)
        wb(1'b1, `REG_CTRL, 32'h22d);
        wb(1'b1, `REG_CTRL, 32'h229);
        wb(1'b0, `REG_STAT, 32'h0);
        `CHK("start ro", 1'b1, rd[`STAT_STARTED])
        @(posedge clk_i);
        event_start_i <= 1'b0;
        cyc_n(3);
        wb(1'b0, `REG_STAT, 32'h0);
        `CHK("event reset", 2'h0, {rd[`STAT_STARTED], rd[`STAT_END]})
        wb(1'b1, `REG_CTRL, 32'h203);
        `CHK("loop pat bank", 3'h0, bank_o)
        wb(1'b1, `REG_CTRL, 32'h227);
        wait_bank(3'h2, 200);
        wait_bank(3'h0, 200);
        `CHK("loop runs", 2'h1, {end_o, run_o})
        `CHK("ramp stopped", 1'b0, ramp_on_o)
        // remote set point far off, then an error with a healthy live value
        @(posedge clk_i);
        rsp_i <= 16'h00c8;
        wb(1'b1, `REG_CTRL, 32'h237);
        cyc_n(25);
        rd_el();
        `CHK("remote sp used", 16'h0, el)
        @(posedge clk_i);
        rsp_err_i <= 1'b1;
        rsp_i <= 16'h0064;
        cyc_n(25);
        rd_el();
        `CHK("remote err held", 16'h0, el)
        wb(1'b1, `REG_CTRL, 32'h0);
        `CHK("off restores", 2'h0, {aux1_end_o, alarm_one_function_moved_o})
        wb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        finish_test();
    end
endmodule // simple_program_sequencer_tb
